// File: rcsel_partner.sv
// Purpose: board side of the reset pin and the monitor enable strap
// Assumes: the reset pin has a pull-up and both parties only pull it low
// Notes:   a released pin reads high, never a held old value
`timescale 1ns/10ps

module rcsel_partner (
    input  wire logic ext_pull,
    input  wire logic mon_level,
    input  wire logic rst_pin_oe,
    input  wire logic rst_pin_n_o,
    output logic      rst_pin_n_i,
    output logic      monitor_enable_pin
);
    assign rst_pin_n_i        = !((rst_pin_oe && !rst_pin_n_o) || ext_pull);
    assign monitor_enable_pin = mon_level;
endmodule // rcsel_partner

// File: rcsel_pkg.sv
// Purpose: types shared by the reset and clock select block
// Assumes: nothing beyond the header
// Notes:   sequencer state encoding
package rcsel_pkg;
    typedef enum logic [1:0] {
        RCSEL_ST_RESET   = 2'b00,
        RCSEL_ST_RELEASE = 2'b01,
        RCSEL_ST_RUN     = 2'b10
    } rcsel_state_t;

    typedef enum logic [0:0] {
        RCSEL_CLK_INT = 1'b0,
        RCSEL_CLK_EXT = 1'b1
    } rcsel_clk_t;
endpackage

// File: rcsel_regs.svh
// Purpose: register offsets, field positions and reset values for the reset and clock select block
// Assumes: AXI4-Lite, 32-bit words, byte addresses
// Notes:   all offsets are word aligned
`ifndef RCSEL_REGS_SVH
`define RCSEL_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RCSEL_OFF_CTRL      4'h0
`define RCSEL_OFF_STATUS    4'h4
`define RCSEL_OFF_CLKSEL    4'h8

// ----------------------------------------
// control fields
// ----------------------------------------
`define RCSEL_CTRL_WDOG_EN  0
`define RCSEL_CTRL_MCLK_EN  1
`define RCSEL_CTRL_CMP_EN   2
`define RCSEL_CTRL_CNV_EN   3
`define RCSEL_CTRL_WDOG_LK  4
`define RCSEL_CTRL_SWRST    5
`define RCSEL_CTRL_RESET    6'h00

// ----------------------------------------
// clock select fields and reset release stretch count
// ----------------------------------------
`define RCSEL_CLKSEL_EXT    0
`define RCSEL_CLKSEL_RESET  1'h0
`define RCSEL_RST_STRETCH   4'h4

`endif

// File: rcsel_top.sv
// Purpose: reset merging and system clock source selection
// Assumes: all source inputs synchronous to aclk, active high requests except the active low reset pin
// Notes:   the register bus keeps running through system reset so status stays readable
`timescale 1ns/10ps
`include "rcsel_regs.svh"

module rcsel_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        por_req,
    input  wire logic        monitor_enable_pin,
    input  wire logic        supply_low,
    input  wire logic        wdog_req,
    input  wire logic        mclk_req,
    input  wire logic        comparator_zero,
    input  wire logic        convert_start_pin,
    input  wire logic        rst_pin_n_i,
    output logic             rst_pin_n_o,
    output logic             rst_pin_oe,
    output logic             sys_rst_n,
    output rcsel_pkg::rcsel_clk_t clk_sel,
    output logic             wdog_run,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import rcsel_pkg::*;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [5:0]          ctrl_reg;
    logic [6:0]          cause_reg;
    logic                por_seen_reg;
    rcsel_state_t        state_reg;
    logic [3:0]          cnt_reg;
    logic                aw_hold_reg;
    logic                w_hold_reg;
    logic [3:0]          awaddr_reg;
    logic [31:0]         wdata_reg;
    // low strobe bit kept with the data, since the master may move wstrb after W is taken
    logic                wstrb0_reg;
    logic                wr_fire;
    logic                src_any;
    logic [6:0]          src_vec;

    // maskable sources; supply gated by the monitor enable pin, reset pin never masked
    always_comb begin
        src_vec[0] = supply_low & monitor_enable_pin;
        src_vec[1] = wdog_req & (ctrl_reg[`RCSEL_CTRL_WDOG_EN] | ctrl_reg[`RCSEL_CTRL_WDOG_LK]);
        src_vec[2] = mclk_req & ctrl_reg[`RCSEL_CTRL_MCLK_EN];
        src_vec[3] = comparator_zero & ctrl_reg[`RCSEL_CTRL_CMP_EN];
        src_vec[4] = ctrl_reg[`RCSEL_CTRL_SWRST];
        src_vec[5] = convert_start_pin & ctrl_reg[`RCSEL_CTRL_CNV_EN];
        src_vec[6] = ~rst_pin_n_i;
        src_any    = (|src_vec) | por_req;
    end

    // ----------------------------------------
    // reset sequencer
    // ----------------------------------------
    // stretched release on one edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= RCSEL_ST_RESET;
            cnt_reg   <= 4'h0;
            sys_rst_n <= 1'b0;
        end else begin
            case (state_reg)
                RCSEL_ST_RESET: begin
                    sys_rst_n <= 1'b0;
                    cnt_reg   <= 4'h0;
                    if (!src_any) begin
                        state_reg <= RCSEL_ST_RELEASE;
                    end
                end
                RCSEL_ST_RELEASE: begin
                    if (src_any) begin
                        state_reg <= RCSEL_ST_RESET;
                    end else if (cnt_reg == `RCSEL_RST_STRETCH) begin
                        state_reg <= RCSEL_ST_RUN;
                        sys_rst_n <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                end
                RCSEL_ST_RUN: begin
                    if (src_any) begin
                        state_reg <= RCSEL_ST_RESET;
                        sys_rst_n <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= RCSEL_ST_RESET;
                    sys_rst_n <= 1'b0;
                end
            endcase
        end
    end

    // drive power-on reset out on the pin, open drain low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_pin_oe  <= 1'b1;
            rst_pin_n_o <= 1'b0;
        end else begin
            rst_pin_oe  <= por_req;
            rst_pin_n_o <= 1'b0;
        end
    end

    // cause bits are sticky; a fresh event wins over a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cause_reg    <= 7'h00;
            por_seen_reg <= 1'b0;
        end else begin
            if (wr_fire && awaddr_reg == `RCSEL_OFF_STATUS && wstrb0_reg) begin
                cause_reg    <= (cause_reg & ~wdata_reg[6:0]) | src_vec;
                por_seen_reg <= (por_seen_reg & ~wdata_reg[7]) | por_req;
            end else begin
                cause_reg    <= cause_reg | src_vec;
                por_seen_reg <= por_seen_reg | por_req;
            end
        end
    end

    // ----------------------------------------
    // control and clock select
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || por_req) begin
            ctrl_reg <= `RCSEL_CTRL_RESET;
        end else if (!sys_rst_n) begin
            // lock survives non power-on resets; the soft reset bit self clears
            ctrl_reg <= ctrl_reg & 6'h10;
        end else if (wr_fire && awaddr_reg == `RCSEL_OFF_CTRL && wstrb0_reg) begin
            ctrl_reg[3:0] <= wdata_reg[3:0];
            ctrl_reg[`RCSEL_CTRL_SWRST] <= wdata_reg[`RCSEL_CTRL_SWRST];
            ctrl_reg[`RCSEL_CTRL_WDOG_LK] <= ctrl_reg[`RCSEL_CTRL_WDOG_LK] |
                                              wdata_reg[`RCSEL_CTRL_WDOG_LK];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_sel  <= RCSEL_CLK_INT;
            wdog_run <= 1'b0;
        end else begin
            wdog_run <= ctrl_reg[`RCSEL_CTRL_WDOG_EN] | ctrl_reg[`RCSEL_CTRL_WDOG_LK];
            // any reset returns to internal oscillator
            if (!sys_rst_n || src_any) begin
                clk_sel <= RCSEL_CLK_INT;
            end else if (wr_fire && awaddr_reg == `RCSEL_OFF_CLKSEL && wstrb0_reg) begin
                clk_sel <= rcsel_clk_t'(wdata_reg[`RCSEL_CLKSEL_EXT]);
            end
        end
    end

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            awaddr_reg    <= 4'h0;
            wdata_reg     <= 32'h0;
            wstrb0_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_reg == `RCSEL_OFF_CTRL ||
                                 awaddr_reg == `RCSEL_OFF_STATUS ||
                                 awaddr_reg == `RCSEL_OFF_CLKSEL) ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                case (s_axi_araddr)
                    `RCSEL_OFF_CTRL:   s_axi_rdata <= {26'h0, ctrl_reg};
                    `RCSEL_OFF_STATUS: s_axi_rdata <= {24'h0, por_seen_reg, cause_reg};
                    `RCSEL_OFF_CLKSEL: s_axi_rdata <= {31'h0, clk_sel};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_reset_follows_src: assert property (@(posedge aclk) disable iff (!aresetn)
        src_any |=> !sys_rst_n) else $error("reset did not follow a source");
    a_pin_always_resets: assert property (@(posedge aclk) disable iff (!aresetn)
        !rst_pin_n_i |=> !sys_rst_n) else $error("reset pin was masked");
    a_monitor_by_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        (supply_low && monitor_enable_pin) |=> !sys_rst_n) else $error("monitor ignored");
    a_por_drives_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        por_req |=> (rst_pin_oe && !rst_pin_n_o)) else $error("por not driven on pin");
    a_lock_sticks: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl_reg[`RCSEL_CTRL_WDOG_LK] && !por_req) |=> ctrl_reg[`RCSEL_CTRL_WDOG_LK])
        else $error("watchdog lock dropped");
    a_lock_runs_wdog: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_reg[`RCSEL_CTRL_WDOG_LK] |=> wdog_run) else $error("locked watchdog stopped");
    a_clk_int_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        !sys_rst_n |=> clk_sel == RCSEL_CLK_INT) else $error("clock not internal in reset");
    a_release_stretch: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(sys_rst_n) |-> $past(!src_any, 5)) else $error("release not stretched");
    a_clk_switch: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && awaddr_reg == `RCSEL_OFF_CLKSEL && wstrb0_reg && sys_rst_n && !src_any)
        |=> clk_sel == rcsel_clk_t'($past(wdata_reg[0]))) else $error("clock switch lost");

endmodule // rcsel_top

// File: test_rcsel_top.sv
// Purpose: self-checking bench for the reset and clock select block
// Assumes: bench drives inputs by non-blocking assignment at rising edges
// Notes:   outputs read at an edge show the value left by the edge before
`timescale 1ns/10ps
`include "rcsel_regs.svh"

module test_rcsel_top;
    import rcsel_pkg::*;
    typedef struct packed {
        logic [5:0] ctrl;
        logic       mon;
        logic [4:0] src;
        logic       pull;
        logic       hit;
    } rcsel_row_t;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        por_req = 1'b0;
    logic        mon = 1'b1;
    logic        pull = 1'b0;
    logic [4:0]  src = 5'h00;
    logic [3:0]  awaddr = 4'h0;
    logic [3:0]  araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [3:0]  wstrb = 4'hf;
    logic        awready, wready, bvalid, arready, rvalid, pin_i, mon_pin;
    logic        pin_o, pin_oe, sys_rst_n, wdog_run;
    logic [1:0]  bresp, rresp, rsp, bsp;
    logic [31:0] rdata, rd;
    rcsel_clk_t  clk_sel;
    int          mismatches = 0;
    int          tests_run = 0;
    // ctrl, monitor pin, sources (supply,wdog,mclk,cmp,cnv), pin pull, reset expected
    rcsel_row_t  rows [11] = '{'{6'h00, 1'b1, 5'h01, 1'b0, 1'b1},
        '{6'h0f, 1'b0, 5'h01, 1'b0, 1'b0}, '{6'h00, 1'b1, 5'h02, 1'b0, 1'b0},
        '{6'h01, 1'b1, 5'h02, 1'b0, 1'b1}, '{6'h00, 1'b1, 5'h04, 1'b0, 1'b0},
        '{6'h02, 1'b1, 5'h04, 1'b0, 1'b1}, '{6'h00, 1'b1, 5'h08, 1'b0, 1'b0},
        '{6'h04, 1'b1, 5'h08, 1'b0, 1'b1}, '{6'h00, 1'b1, 5'h10, 1'b0, 1'b0},
        '{6'h08, 1'b1, 5'h10, 1'b0, 1'b1}, '{6'h00, 1'b1, 5'h00, 1'b1, 1'b1}};

    rcsel_top dut_u (.aclk(aclk), .aresetn(aresetn), .por_req(por_req),
        .monitor_enable_pin(mon_pin), .supply_low(src[0]), .wdog_req(src[1]),
        .mclk_req(src[2]), .comparator_zero(src[3]), .convert_start_pin(src[4]),
        .rst_pin_n_i(pin_i), .rst_pin_n_o(pin_o), .rst_pin_oe(pin_oe),
        .sys_rst_n(sys_rst_n), .clk_sel(clk_sel), .wdog_run(wdog_run),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    rcsel_partner partner_u (.ext_pull(pull), .mon_level(mon), .rst_pin_oe(pin_oe),
        .rst_pin_n_o(pin_o), .rst_pin_n_i(pin_i), .monitor_enable_pin(mon_pin));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task results();
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s saw %h wanted %h", $time, what, seen, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // a fresh edge first, so a strobe lowered by the last call is not raised in one step
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                bsp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task rdr(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                rd = rdata;
                rsp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
    task wait_rel();
        int n;
        n = 0;
        while (sys_rst_n !== 1'b1 && n < 30) begin
            @(posedge aclk);
            n++;
        end
        chk({31'h0, sys_rst_n}, 32'h1, "reset release");
    endtask

    initial begin
        forever #25 aclk = ~aclk;
    end
    // generous: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        results();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        tick(3);
        chk({31'h0, pin_oe}, 32'h1, "pin driven in reset");
        chk({31'h0, clk_sel}, 32'h0, "clock in reset");
        aresetn <= 1'b1;
        wait_rel();
        foreach (rows[i]) begin
            mon <= rows[i].mon;
            wr(`RCSEL_OFF_CTRL, {26'h0, rows[i].ctrl});
            wr(`RCSEL_OFF_CLKSEL, 32'h1);
            tick(2);
            chk({31'h0, clk_sel}, {31'h0, RCSEL_CLK_EXT}, "switch on the fly");
            src <= rows[i].src;
            pull <= rows[i].pull;
            tick(3);
            chk({31'h0, !sys_rst_n}, {31'h0, rows[i].hit}, "merge and mask");
            chk({31'h0, clk_sel}, {31'h0, !rows[i].hit}, "clock after reset");
            src <= 5'h00;
            pull <= 1'b0;
            tick(4);
            chk({31'h0, sys_rst_n}, 32'h1 & {31'h0, !rows[i].hit}, "held low");
            wait_rel();
        end
        wr(`RCSEL_OFF_CTRL, 32'h20);
        tick(3);
        chk({31'h0, sys_rst_n}, 32'h0, "software reset");
        wait_rel();
        rdr(`RCSEL_OFF_CTRL);
        chk(rd, 32'h0, "software reset clears");
        por_req <= 1'b1;
        tick(3);
        chk({31'h0, pin_oe}, 32'h1, "por drives pin");
        chk({31'h0, pin_i}, 32'h0, "pin level low");
        chk({31'h0, pin_o}, 32'h0, "pin pulled low");
        por_req <= 1'b0;
        wait_rel();
        wr(`RCSEL_OFF_CTRL, 32'h11);
        wr(`RCSEL_OFF_CTRL, 32'h00);
        tick(2);
        chk({31'h0, wdog_run}, 32'h1, "locked watchdog runs");
        rdr(`RCSEL_OFF_CTRL);
        chk(rd, 32'h10, "lock sticks");
        src <= 5'h02;
        tick(3);
        chk({31'h0, sys_rst_n}, 32'h0, "locked watchdog resets");
        src <= 5'h00;
        wait_rel();
        rdr(`RCSEL_OFF_STATUS);
        chk(rd, 32'hff, "sticky causes");
        wr(`RCSEL_OFF_STATUS, 32'hff);
        rdr(`RCSEL_OFF_STATUS);
        chk(rd, 32'h0, "causes cleared");
        wstrb <= 4'h0;
        wr(`RCSEL_OFF_CTRL, 32'h0f);
        wstrb <= 4'hf;
        rdr(`RCSEL_OFF_CTRL);
        chk(rd, 32'h10, "masked strobe");
        wr(`RCSEL_OFF_CLKSEL, 32'h1);
        chk({30'h0, bsp}, 32'h0, "write okay");
        rdr(`RCSEL_OFF_CLKSEL);
        chk(rd, 32'h1, "clock readback");
        wr(`RCSEL_OFF_CLKSEL, 32'h0);
        tick(2);
        chk({31'h0, clk_sel}, 32'h0, "back to internal");
        wr(4'hc, 32'h1);
        chk({30'h0, bsp}, 32'h2, "unmapped write response");
        rdr(4'hc);
        chk({30'h0, rsp}, 32'h2, "unmapped response");
        chk(rd, 32'h0, "unmapped data");
        results();
    end
endmodule // test_rcsel_top
